// file: logic/psr_regs.sv
/*
 * psr_regs: APB slave holding the PHY status register and the high half of
 * the PHY identifier.
 * Assumes phy_in comes from PHY logic on mclk (no synchroniser needed) and
 * that sticky inputs are held high for at least one cycle per event.
 */
// The APB register port is this design's own decision.
module psr_regs #(
   parameter int          ADDR_W     = 12,
   parameter logic [15:0] IDENT_HIGH = psr_pkg::IDENT_HIGH_DEF
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ADDR_W-1:0]      paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   input  wire psr_pkg::psr_phy_in_type phy_in,
   output logic [15:0]                 phy_status
);

   if (ADDR_W < 4) begin : g_chk
      $error("psr_regs: ADDR_W must be at least 4");
   end

   psr_pkg::psr_state_type st_r;
   psr_pkg::psr_state_type st_nxt;

   // composes the status word from live state
   function automatic logic [15:0] status_word(input psr_pkg::psr_state_type s);
      logic [15:0] w;
      w = psr_pkg::STATUS_FIXED;
      w[psr_pkg::BIT_LINK]      = s.link;
      w[psr_pkg::BIT_JABBER]    = s.jabber_flag;
      w[psr_pkg::BIT_FAR_FAULT] = s.far_fault_flag;
      w[psr_pkg::BIT_AUTONEG]   = s.autoneg_done;
      return w;
   endfunction : status_word

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a == ADDR_W'(32'(idx) * psr_pkg::BYTE_PER_REG);
   endfunction : addr_is

   logic setup;
   logic rd_status_done;
   logic pwdata_unused;

   assign pready         = 1'b1;
   assign setup          = psel & ~penable;
   // clear only what the read actually returned, so an event landing meanwhile survives
   assign rd_status_done = psel & penable & ~pwrite & addr_is(paddr, psr_pkg::IDX_STATUS);
   assign pwdata_unused  = ^pwdata;

   always_comb begin
      st_nxt              = st_r;
      st_nxt.link         = phy_in.link_up;
      st_nxt.autoneg_done = phy_in.autoneg_done;
      if (rd_status_done) begin
         st_nxt.jabber_flag    = st_r.jabber_flag & ~st_r.prdata[psr_pkg::BIT_JABBER];
         st_nxt.far_fault_flag = st_r.far_fault_flag & ~st_r.prdata[psr_pkg::BIT_FAR_FAULT];
      end
      // set wins over clear
      if (phy_in.jabber_seen) begin
         st_nxt.jabber_flag = 1'b1;
      end
      if (phy_in.far_fault_seen) begin
         st_nxt.far_fault_flag = 1'b1;
      end
      if (setup) begin
         st_nxt.pslverr = 1'b0;
         st_nxt.prdata  = 32'h0000_0000;
         if (addr_is(paddr, psr_pkg::IDX_STATUS)) begin
            // writes are accepted and dropped
            if (!pwrite) begin
               st_nxt.prdata = {16'h0000, status_word(st_r)};
            end
         end else if (addr_is(paddr, psr_pkg::IDX_IDENT_HIGH)) begin
            if (!pwrite) begin
               st_nxt.prdata = {16'h0000, IDENT_HIGH};
            end
         end else begin
            st_nxt.pslverr = 1'b1;
         end
      end
      if (!rst_n) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge mclk) begin
      st_r <= st_nxt;
   end

   assign prdata     = st_r.prdata;
   assign pslverr    = st_r.pslverr & psel & penable;
   assign phy_status = status_word(st_r);

endmodule : psr_regs

// file: logic/psr_pkg.sv
/*
 * psr_pkg: constants and carrier types for the PHY status and identifier
 * register bank.
 * Assumes a 32-bit APB slave on mclk, with registers one word apart at byte
 * address = 4 * register index.
 */
// Behaviour
// - status register at index 0x01 is read-only, reset reads 0x7849, writes ignored
// - status bits 14 and 13 are constant ones: 100 Mb/s full and half duplex
// - status bits 12 and 11 are constant ones: 10 Mb/s full and half duplex
// - status bit 3 is a constant one: auto-negotiation is supported
// - status bit 2 follows the link state, zero after reset
// - status bit 1 sets when a jabber condition is detected
// - jabber bit stays set after the condition ends; a status read clears it
// - status bit 0 is a constant one: extended register set present
// - identifier register at index 0x02 is read-only, first half of 32-bit code
// - identifier high word holds upper organisation id; low six bits live elsewhere
package psr_pkg;

   localparam logic [7:0]  IDX_STATUS      = 8'h01;
   localparam logic [7:0]  IDX_IDENT_HIGH  = 8'h02;
   localparam int          BYTE_PER_REG    = 4;

   localparam logic [15:0] STATUS_RESET    = 16'h7849;
   // bits that never change: capabilities, preamble suppression, extended set
   localparam logic [15:0] STATUS_FIXED    = 16'h7849;

   localparam int          BIT_LINK        = 2;
   localparam int          BIT_JABBER      = 1;
   localparam int          BIT_FAR_FAULT   = 4;
   localparam int          BIT_AUTONEG     = 5;

   // arbitrary neutral identifier value, not a real organisation id
   localparam logic [15:0] IDENT_HIGH_DEF  = 16'h1234;

   typedef struct packed {
      logic link_up;
      logic autoneg_done;
      logic jabber_seen;
      logic far_fault_seen;
   } psr_phy_in_type;

   typedef struct packed {
      logic        link;
      logic        autoneg_done;
      logic        jabber_flag;
      logic        far_fault_flag;
      logic [31:0] prdata;
      logic        pslverr;
   } psr_state_type;

endpackage : psr_pkg

// file: test/psr_regs_props.sv
/* psr_props: timing relations on the status/ident bank ports.
   Assumes psr_regs with ADDR_W of 12, bound below. */
module psr_props (
   input wire logic                    mclk,
   input wire logic                    rst_n,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             prdata,
   input wire psr_pkg::psr_phy_in_type phy_in,
   input wire logic [15:0]             phy_status
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire rd_st = psel && penable && !pwrite && paddr == 12'h004;
   a_fixed_ones: assert property ((phy_status & 16'h7849) == 16'h7849) else $error("fixed bit low");
   a_resv_zero: assert property ((phy_status & 16'h8780) == 16'h0000) else $error("reserved set");
   a_link_lag: assert property ($past(rst_n) |-> phy_status[2] == $past(phy_in.link_up)) else $error("link");
   a_anc_lag: assert property ($past(rst_n) |-> phy_status[5] == $past(phy_in.autoneg_done)) else $error("anc");
   a_jab_set: assert property (phy_in.jabber_seen |=> phy_status[1]) else $error("jabber set");
   a_jab_hold: assert property (phy_status[1] && !rd_st |=> phy_status[1]) else $error("jabber hold");
   a_fault_set: assert property (phy_in.far_fault_seen |=> phy_status[4]) else $error("fault set");
   a_fault_hold: assert property (phy_status[4] && !rd_st |=> phy_status[4]) else $error("fault hold");
   a_read_snap: assert property (psel && !penable && !pwrite && paddr == 12'h004
      |=> prdata == {16'h0000, $past(phy_status)}) else $error("status read");
endmodule : psr_props
bind psr_regs psr_props u_props (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .phy_in(phy_in), .phy_status(phy_status));

// file: test/psr_regs_tb.sv
/* psr_regs_tb: status and ident reads over APB.
   Assumes a zero-wait slave and default parameters. */
module psr_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] prdata;
   logic [15:0] phy_status;
   psr_pkg::psr_phy_in_type phy_in = '0;
   int errors = 0, compares = 0;
   always #5 mclk = ~mclk;
   psr_regs dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(32'hFFFF_FFFF), .pready(pready), .prdata(prdata), .pslverr(pslverr), .phy_in(phy_in),
      .phy_status(phy_status));
   task results;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // write data is all ones so a write that leaks shows up
   task acc(input logic [11:0] a, input logic w, input logic [31:0] x, input logic e);
      int n;
      @(posedge mclk);
      psel <= 1;
      paddr <= a;
      pwrite <= w;
      @(posedge mclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      psel <= 0;
      penable <= 0;
      compares++;
      if (n >= 9 || prdata !== x || pslverr !== e) begin
         errors++;
         $display("BAD word %h exp %h/%b got %h/%b", a, x, e, prdata, pslverr);
         if (n >= 9) results();
      end
   endtask : acc
   task t_reset_ro;
      compares++;
      if (phy_status !== 16'h7849) begin
         errors++;
         $display("BAD phy_status exp 7849 got %h", phy_status);
      end
      acc(12'h004, 0, 32'h0000_7849, 0);
      acc(12'h004, 1, 32'h0, 0);
      acc(12'h004, 0, 32'h0000_7849, 0);
      acc(12'h008, 0, {16'h0000, psr_pkg::IDENT_HIGH_DEF}, 0);
      acc(12'h00C, 0, 32'h0, 1);
   endtask : t_reset_ro
   task t_sticky;
      phy_in <= 4'hF;
      @(posedge mclk);
      phy_in <= 4'hC;
      acc(12'h004, 0, 32'h0000_787F, 0);
      acc(12'h004, 0, 32'h0000_786D, 0);
   endtask : t_sticky
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1;
      t_reset_ro();
      t_sticky();
      results();
   end
endmodule : psr_regs_tb
